/* hw/snv_pkg.sv */
// Purpose: Shared constants for the serial nonvolatile memory slave
// Assumes: 256K x 8 array, 100 MHz system clock
// Notes:   Times are given in their own unit, cycles derived
package snv_pkg;
   localparam int ADDR_W = 18;
   localparam int SYNC_W = 5;
   // Synchroniser reset: {wpN, holdN, si, sck, csN}
   localparam logic [4:0]  SYNC_RST    = 5'h19;
   localparam logic [7:0]  OP_SET_WEL  = 8'h06;
   localparam logic [7:0]  OP_CLR_WEL  = 8'h04;
   localparam logic [7:0]  OP_SR_RD    = 8'h05;
   localparam logic [7:0]  OP_SR_WR    = 8'h01;
   localparam logic [7:0]  OP_READ     = 8'h03;
   localparam logic [7:0]  OP_WRITE    = 8'h02;
   localparam logic [7:0]  OP_FAST     = 8'h0B;
   localparam logic [7:0]  OP_ID       = 8'h9F;
   localparam logic [7:0]  OP_SLEEP    = 8'hB9;
   localparam logic [4:0]  OPC_LAST    = 5'h07;
   localparam logic [4:0]  ADDR_LAST   = 5'h17;
   localparam logic [2:0]  NV_RST      = 3'h0;
   localparam logic [1:0]  BP_RST      = 2'h0;
   // Identity value is arbitrary
   localparam logic [31:0] ID_VALUE    = 32'h5A01_3C07;
   localparam int CLK_MHZ        = 100;
   localparam int WAKE_TIME_US   = 400;
   localparam int WAKE_CYC       = WAKE_TIME_US * CLK_MHZ;

   typedef enum logic [3:0] {
      ST_OPC, ST_ADDR, ST_DUMMY, ST_RDOUT, ST_WRDATA,
      ST_SRIN, ST_SROUT, ST_IDOUT, ST_SLEEPARM, ST_IGNORE
   } snv_state_e;

   function automatic logic snvProt(input logic [1:0] bp,
                                    input logic [ADDR_W-1:0] a);
      logic p;
      p = 1'b0;
      if (bp == 2'h1) begin
         p = (a[17:16] == 2'h3);
      end else if (bp == 2'h2) begin
         p = a[17];
      end else if (bp == 2'h3) begin
         p = 1'b1;
      end
      return p;
   endfunction : snvProt

   function automatic logic [ADDR_W-1:0] snvInc(
      input logic [ADDR_W-1:0] a);
      return a + 18'h00001;
   endfunction : snvInc
endpackage : snv_pkg

/* hw/snv_mem_if.sv */
// Purpose: Carrier between command logic and the array
// Assumes: One write or read port, registered read data
// Notes:   None
`timescale 1ns/1ps
interface snv_mem_if;
   logic [17:0] addr;
   logic [7:0]  wdata;
   logic        we;
   logic [7:0]  rdata;
   modport ctrl  (output addr, output wdata, output we, input rdata);
   modport store (input addr, input wdata, input we, output rdata);
endinterface : snv_mem_if

/* hw/snv_sync.sv */
// Purpose: Two-stage synchroniser for the serial pins
// Assumes: Pins are asynchronous to clock
// Notes:   First stage read only by the second
`timescale 1ns/1ps
module snv_sync (
   // System
   input  wire logic                       clock,
   input  wire logic                       reset,
   // Pins
   input  wire logic [snv_pkg::SYNC_W-1:0] din,
   output logic      [snv_pkg::SYNC_W-1:0] dout
);
   logic [snv_pkg::SYNC_W-1:0] stage1;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         stage1 <= snv_pkg::SYNC_RST;
         dout   <= snv_pkg::SYNC_RST;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule : snv_sync

/* hw/snv_mem.sv */
// Purpose: 256K x 8 storage array
// Assumes: Contents undefined at power-up
// Notes:   Read data is registered every cycle
`timescale 1ns/1ps
module snv_mem (
   // System
   input  wire logic clock,
   // Access
   snv_mem_if.store  m
);
   logic [7:0] cells [0:(1 << snv_pkg::ADDR_W) - 1];
   always_ff @(posedge clock) begin
      if (m.we) begin
         cells[m.addr] <= m.wdata;
      end
      m.rdata <= cells[m.addr];
   end
endmodule : snv_mem

/* hw/snv_top.sv */
// Purpose: Serial command slave of a 256K x 8 nonvolatile memory
// Assumes: Pins sampled by clock, SCK far slower than clock
// Notes:   Reset stands for power-on
// How it works
// - Eight-bit op-code first; chip select rising early cancels it.
// - Op-code 06 sets the write latch, 04 clears it.
// - No status or array write while the write latch is clear.
// - Status read repeats the status byte on SO while clocks continue.
// - Status write takes one byte; latch bit and bit 0 ignored.
// - Read takes 24-bit address, upper 6 bits ignored, data on SO.
// - Read bursts increment address and wrap to zero at top.
// - Write stores each byte once its eight bits have arrived.
// - Further write bytes go to incremented, wrapping addresses.
// - Fast read adds eight dummy clocks, otherwise like read.
// - Identity read shifts out 32 bits: maker, continuation, product.
// - After 32 identity bits SO holds the last bit.
// - Sleep entered at chip select rise unless SCK clocked meanwhile.
// - Asleep: ignore SCK and SI, SO high impedance.
// - Chip select fall wakes; normal operation within 400 us.
// - Block-protect bits choose the write-refused upper range.
// - Status write also refused when protect-enable set and pin low.
// - Hold low pauses command, ignores SCK and SI, SO off.
// - Chip select rise during hold aborts; unrecognised keeps latch.
// - SI sampled on SCK rise, SO changed on SCK fall.
// - Latch cleared at power-on, clear op-code, rise after writes.
// - Chip select high: standby, inputs ignored, SO off.
`timescale 1ns/1ps
module snv_top #(
   parameter int unsigned WAKE_CYCLES = snv_pkg::WAKE_CYC
) (
   // System
   input  wire logic clock,
   input  wire logic reset,
   // Serial pins
   input  wire logic csN,
   input  wire logic sck,
   input  wire logic si,
   input  wire logic holdN,
   input  wire logic wpN,
   output logic      so,
   output logic      soOe,
   // Status
   output logic      sleeping
);
   logic [4:0]  pins;
   logic        csS, sckS, siS, holdS, wpS;
   logic        sckPrev, csPrev, sckRise, sckFall, csRise, csFall;
   snv_pkg::snv_state_e state, next_state;
   logic [4:0]  cnt, next_cnt;
   logic [7:0]  cmd, next_cmd;
   logic [23:0] sh, next_sh;
   logic [17:0] addr, next_addr;
   logic [7:0]  outSh, next_outSh;
   logic [2:0]  outBit, next_outBit;
   logic [31:0] idSh, next_idSh;
   logic        write_enable_latch, next_wel;
   logic        spe, next_spe;
   logic [2:0]  nv, next_nv;
   logic [1:0]  bp, next_bp;
   logic        recogWr, next_recogWr;
   logic        waking, next_waking;
   logic [15:0] wakeCnt, next_wakeCnt;
   logic        soActive, next_soActive;
   logic        next_so, next_soOe, next_sleeping;
   logic        memWe, next_memWe;
   logic [17:0] memAddr, next_memAddr;
   logic [7:0]  memWdata, next_memWdata;
   logic [7:0]  status;

   snv_mem_if mi ();

   snv_sync u_sync (
      .clock (clock),
      .reset (reset),
      .din   ({wpN, holdN, si, sck, csN}),
      .dout  (pins)
   );

   snv_mem u_mem (
      .clock (clock),
      .m     (mi.store)
   );

   assign {wpS, holdS, siS, sckS, csS} = pins;
   assign mi.addr  = memAddr;
   assign mi.wdata = memWdata;
   assign mi.we    = memWe;
   assign sckRise  = sckS & ~sckPrev;
   assign sckFall  = ~sckS & sckPrev;
   assign csRise   = csS & ~csPrev;
   assign csFall   = ~csS & csPrev;
   assign status   = {spe, nv, bp, write_enable_latch, 1'b0};

   always_comb begin
      logic [7:0] outByte;
      logic [7:0] opc;
      outByte       = outSh;
      opc           = {sh[6:0], siS};
      next_state    = state;
      next_cnt      = cnt;
      next_cmd      = cmd;
      next_sh       = sh;
      next_addr     = addr;
      next_outSh    = outSh;
      next_outBit   = outBit;
      next_idSh     = idSh;
      next_wel      = write_enable_latch;
      next_spe      = spe;
      next_nv       = nv;
      next_bp       = bp;
      next_recogWr  = recogWr;
      next_waking   = waking;
      next_wakeCnt  = wakeCnt;
      next_soActive = soActive;
      next_so       = so;
      next_sleeping = sleeping;
      next_memWe    = 1'b0;
      next_memWdata = memWdata;
      if (sleeping) begin
         next_state    = snv_pkg::ST_OPC;
         next_cnt      = 5'h00;
         next_soActive = 1'b0;
         if (waking) begin
            if (wakeCnt == 16'h0000) begin
               next_waking   = 1'b0;
               next_sleeping = 1'b0;
            end else begin
               next_wakeCnt = wakeCnt - 16'h0001;
            end
         end else if (csFall) begin
            next_waking  = 1'b1;
            next_wakeCnt = 16'(WAKE_CYCLES - 1);
         end
      end else if (csS) begin
         if (csRise) begin
            next_sleeping = (state == snv_pkg::ST_SLEEPARM);
            next_wel      = write_enable_latch & ~recogWr;
         end
         next_state    = snv_pkg::ST_OPC;
         next_cnt      = 5'h00;
         next_outBit   = 3'h0;
         next_recogWr  = 1'b0;
         next_soActive = 1'b0;
      end else if (holdS) begin
         if (sckRise) begin
            next_sh  = {sh[22:0], siS};
            next_cnt = cnt + 5'h01;
            case (state)
               snv_pkg::ST_OPC: begin
                  if (cnt == snv_pkg::OPC_LAST) begin
                     next_cnt = 5'h00;
                     next_cmd = opc;
                     next_state = snv_pkg::ST_IGNORE;
                     if (opc == snv_pkg::OP_SET_WEL) begin
                        next_wel = 1'b1;
                     end else if (opc == snv_pkg::OP_CLR_WEL) begin
                        next_wel = 1'b0;
                     end else if (opc == snv_pkg::OP_SR_RD) begin
                        next_state = snv_pkg::ST_SROUT;
                     end else if (opc == snv_pkg::OP_SR_WR) begin
                        next_state   = snv_pkg::ST_SRIN;
                        next_recogWr = 1'b1;
                     end else if (opc == snv_pkg::OP_WRITE) begin
                        next_state   = snv_pkg::ST_ADDR;
                        next_recogWr = 1'b1;
                     end else if (opc == snv_pkg::OP_READ ||
                                  opc == snv_pkg::OP_FAST) begin
                        next_state = snv_pkg::ST_ADDR;
                     end else if (opc == snv_pkg::OP_ID) begin
                        next_state = snv_pkg::ST_IDOUT;
                        next_idSh  = snv_pkg::ID_VALUE;
                     end else if (opc == snv_pkg::OP_SLEEP) begin
                        next_state = snv_pkg::ST_SLEEPARM;
                     end
                  end
               end
               snv_pkg::ST_ADDR: begin
                  if (cnt == snv_pkg::ADDR_LAST) begin
                     next_cnt  = 5'h00;
                     next_addr = {sh[16:0], siS};
                     if (cmd == snv_pkg::OP_FAST) begin
                        next_state = snv_pkg::ST_DUMMY;
                     end else if (cmd == snv_pkg::OP_WRITE) begin
                        next_state = snv_pkg::ST_WRDATA;
                     end else begin
                        next_state = snv_pkg::ST_RDOUT;
                     end
                  end
               end
               snv_pkg::ST_DUMMY: begin
                  if (cnt == snv_pkg::OPC_LAST) begin
                     next_cnt   = 5'h00;
                     next_state = snv_pkg::ST_RDOUT;
                  end
               end
               snv_pkg::ST_WRDATA: begin
                  if (cnt == snv_pkg::OPC_LAST) begin
                     next_cnt = 5'h00;
                     next_addr = snv_pkg::snvInc(addr);
                     if (write_enable_latch && !snv_pkg::snvProt(bp, addr)) begin
                        next_memWe    = 1'b1;
                        next_memWdata = opc;
                     end
                  end
               end
               snv_pkg::ST_SRIN: begin
                  if (cnt == snv_pkg::OPC_LAST) begin
                     next_state = snv_pkg::ST_IGNORE;
                     if (write_enable_latch && !(spe && !wpS)) begin
                        next_spe = opc[7];
                        next_nv  = opc[6:4];
                        next_bp  = opc[3:2];
                     end
                  end
               end
               snv_pkg::ST_SLEEPARM: next_state = snv_pkg::ST_IGNORE;
               default: next_cnt = cnt;
            endcase
         end
         if (sckFall) begin
            case (state)
               snv_pkg::ST_SROUT, snv_pkg::ST_RDOUT: begin
                  if (outBit == 3'h0) begin
                     if (state == snv_pkg::ST_SROUT) begin
                        outByte = status;
                     end else begin
                        outByte   = mi.rdata;
                        next_addr = snv_pkg::snvInc(addr);
                     end
                  end
                  next_so       = outByte[7];
                  next_outSh    = {outByte[6:0], 1'b0};
                  next_outBit   = outBit + 3'h1;
                  next_soActive = 1'b1;
               end
               snv_pkg::ST_IDOUT: begin
                  next_so       = idSh[31];
                  next_idSh     = {idSh[30:0], idSh[0]};
                  next_soActive = 1'b1;
               end
               default: next_so = so;
            endcase
         end
      end
      next_soOe = next_soActive & holdS & ~csS & ~next_sleeping;
      next_memAddr = next_memWe ? addr : next_addr;
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sckPrev  <= 1'b0;
         csPrev   <= 1'b1;
         state    <= snv_pkg::ST_OPC;
         cnt      <= 5'h00;
         cmd      <= 8'h00;
         sh       <= 24'h000000;
         addr     <= 18'h00000;
         outSh    <= 8'h00;
         outBit   <= 3'h0;
         idSh     <= 32'h00000000;
         write_enable_latch      <= 1'b0;
         spe      <= 1'b0;
         nv       <= snv_pkg::NV_RST;
         bp       <= snv_pkg::BP_RST;
         recogWr  <= 1'b0;
         waking   <= 1'b0;
         wakeCnt  <= 16'h0000;
         soActive <= 1'b0;
         so       <= 1'b0;
         soOe     <= 1'b0;
         sleeping <= 1'b0;
         memWe    <= 1'b0;
         memAddr  <= 18'h00000;
         memWdata <= 8'h00;
      end else begin
         sckPrev  <= sckS;
         csPrev   <= csS;
         state    <= next_state;
         cnt      <= next_cnt;
         cmd      <= next_cmd;
         sh       <= next_sh;
         addr     <= next_addr;
         outSh    <= next_outSh;
         outBit   <= next_outBit;
         idSh     <= next_idSh;
         write_enable_latch      <= next_wel;
         spe      <= next_spe;
         nv       <= next_nv;
         bp       <= next_bp;
         recogWr  <= next_recogWr;
         waking   <= next_waking;
         wakeCnt  <= next_wakeCnt;
         soActive <= next_soActive;
         so       <= next_so;
         soOe     <= next_soOe;
         sleeping <= next_sleeping;
         memWe    <= next_memWe;
         memAddr  <= next_memAddr;
         memWdata <= next_memWdata;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   AST_STANDBY_Z: assert property (csS |=> !soOe)
      else $error("SO driven while deselected");
   AST_HOLD_Z: assert property (!holdS |=> !soOe)
      else $error("SO driven during hold");
   AST_SLEEP_Z: assert property (sleeping |=> !soOe ##1 !soOe)
      else $error("SO driven while asleep");
   AST_WEL_SET: assert property (
      sckRise && holdS && !csS && !sleeping && state == snv_pkg::ST_OPC &&
      cnt == snv_pkg::OPC_LAST && {sh[6:0], siS} == snv_pkg::OP_SET_WEL
      |=> write_enable_latch) else $error("Latch not set by set op-code");
   AST_WEL_CLR: assert property (csRise && recogWr |=> !write_enable_latch)
      else $error("Latch not cleared after write command");
   AST_WR_GUARD: assert property (
      memWe |-> write_enable_latch && !snv_pkg::snvProt(bp, memAddr))
      else $error("Array write without permission");
   AST_SR_GUARD: assert property (!write_enable_latch |=> $stable({spe, nv, bp}))
      else $error("Status changed with latch clear");
   AST_SLEEP_IN: assert property (
      csRise && !sleeping && state == snv_pkg::ST_SLEEPARM |=> sleeping [*2])
      else $error("Sleep not entered");
   AST_WRAP: assert property (
      state == snv_pkg::ST_RDOUT && sckFall && holdS && !csS && !sleeping &&
      outBit == 3'h0 && addr == 18'h3FFFF |=> addr == 18'h00000)
      else $error("Read address did not wrap");

   COV_BURST: cover property (state == snv_pkg::ST_RDOUT && outBit == 3'h7
      ##[1:200] outBit == 3'h0);
   COV_WRITE: cover property (memWe ##[1:200] memWe);
   COV_SLEEP: cover property (sleeping ##[1:1000] !sleeping);
   COV_ID: cover property (state == snv_pkg::ST_IDOUT && soOe);
endmodule : snv_top

/* tb/snv_host.sv */
// Purpose: SPI host model driving the memory slave pins
// Assumes: Mode 0 or 3, SCK period 8 clock cycles (80 ns)
// Notes:   SI toggles every cycle while deselected
`timescale 1ns/1ps
module snv_host (
   // System
   input  wire logic clock,
   // Serial pins
   output logic      csN,
   output logic      sck,
   output logic      si,
   output logic      holdN,
   output logic      wpN,
   input  wire logic so
);
   logic idle;

   initial begin
      idle  = 1'b0;
      csN   = 1'b1;
      sck   = 1'b0;
      si    = 1'b0;
      holdN = 1'b1;
      wpN   = 1'b1;
   end

   // Released data line shows no stale value
   always @(posedge clock) begin
      if (csN) begin
         si <= ~si;
      end
   end

   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask : wt

   task automatic start;
      @(posedge clock);
      csN <= 1'b0;
      wt(4);
   endtask : start

   task automatic stop;
      wt(4);
      csN <= 1'b1;
      wt(8);
   endtask : stop

   // Shifts n bits of tx from the top, so taken just before each fall
   task automatic xfer(input logic [7:0] tx, input int n,
                       output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         if (idle) sck <= 1'b0;
         si <= tx[i];
         wt(4);
         sck <= 1'b1;
         wt(4);
         rx[i] = so;
         if (!idle) sck <= 1'b0;
      end
   endtask : xfer

   task automatic pulse;
      wt(4);
      sck <= ~idle;
      wt(4);
      sck <= idle;
   endtask : pulse

   // Hold changes only while SCK is at its idle level
   task automatic hold(input logic lvl);
      wt(2);
      holdN <= lvl;
      wt(6);
   endtask : hold

   // Write-protect level settles outside frames
   task automatic pin(input logic lvl);
      wpN <= lvl;
      wt(2);
   endtask : pin

   // Idle SCK level picks mode 0 or mode 3, set outside frames
   task automatic mode(input logic lvl);
      idle = lvl;
      sck  <= lvl;
      wt(2);
   endtask : mode
endmodule : snv_host

/* tb/tb_spi_nv_memory_command_slave.sv */
// Purpose: Self-checking bench for the serial memory command slave
// Assumes: Wake count shortened to 20 cycles
// Notes:   Queue-free model of array and status bits
`timescale 1ns/1ps
module tb_spi_nv_memory_command_slave;
   localparam int LIMIT = 80000;
   logic       clock;
   logic       reset;
   logic       csN;
   logic       sck;
   logic       si;
   logic       holdN;
   logic       wpN;
   logic       so;
   logic       soOe;
   logic       sleeping;
   logic       soPin;
   logic [7:0] mem [int];
   logic       spe;
   logic [2:0] spare;
   logic [1:0] bp;
   logic       latch;
   int         fail_count;
   int         checks;
   int         cyc;

   snv_top #(.WAKE_CYCLES(20)) dut (.clock(clock), .reset(reset),
      .csN(csN), .sck(sck), .si(si), .holdN(holdN), .wpN(wpN),
      .so(so), .soOe(soOe), .sleeping(sleeping));
   snv_host host (.clock(clock), .csN(csN), .sck(sck), .si(si),
      .holdN(holdN), .wpN(wpN), .so(soPin));

   // Released SO line reads as the inverse of the last value
   assign soPin = soOe ? so : ~so;

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   always @(posedge clock) begin
      cyc++;
      if (cyc == LIMIT) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic check(input string nm, input logic [7:0] exp,
                        input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   function automatic bit prot(input int a);
      case (bp)
         2'h1: return a >= 32'h30000;
         2'h2: return a >= 32'h20000;
         2'h3: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : prot

   task automatic op(input logic [7:0] c);
      logic [7:0] r;
      host.start();
      host.xfer(c, 8, r);
      host.stop();
      if (c == snv_pkg::OP_SET_WEL) latch = 1'b1;
      if (c == snv_pkg::OP_CLR_WEL) latch = 1'b0;
   endtask : op

   task automatic sendAddr(input logic [7:0] c, input logic [23:0] a);
      logic [7:0] r;
      host.start();
      host.xfer(c, 8, r);
      host.xfer(a[23:16], 8, r);
      host.xfer(a[15:8], 8, r);
      host.xfer(a[7:0], 8, r);
   endtask : sendAddr

   task automatic wr(input logic [23:0] a, input int n);
      logic [7:0] r;
      logic [7:0] d;
      int         k;
      sendAddr(snv_pkg::OP_WRITE, a);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         k = (int'(a[17:0]) + i) & 32'h3FFFF;
         host.xfer(d, 8, r);
         if (latch && !prot(k)) mem[k] = d;
      end
      host.stop();
      latch = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] c, input logic [23:0] a,
                     input int n, input bit hld);
      logic [7:0] r;
      int         k;
      sendAddr(c, a);
      if (c == snv_pkg::OP_FAST) host.xfer(8'($urandom), 8, r);
      for (int i = 0; i < n; i++) begin
         k = (int'(a[17:0]) + i) & 32'h3FFFF;
         host.xfer(8'($urandom), 8, r);
         check("read data", mem[k], r);
         if (hld && i == 0) begin
            host.hold(1'b0);
            check("so enable in hold", 8'h00, 8'(soOe));
            host.pulse();
            host.pulse();
            host.hold(1'b1);
         end
      end
      host.stop();
      check("so enable idle", 8'h00, 8'(soOe));
   endtask : rd

   task automatic srd(input int n);
      logic [7:0] r;
      host.start();
      host.xfer(snv_pkg::OP_SR_RD, 8, r);
      for (int i = 0; i < n; i++) begin
         host.xfer(8'($urandom), 8, r);
         check("status", {spe, spare, bp, latch, 1'b0}, r);
      end
      host.stop();
   endtask : srd

   task automatic srw(input logic [7:0] d);
      logic [7:0] r;
      host.start();
      host.xfer(snv_pkg::OP_SR_WR, 8, r);
      host.xfer(d, 8, r);
      host.stop();
      if (latch && !(spe && !wpN)) {spe, spare, bp} = d[7:2];
      latch = 1'b0;
   endtask : srw

   task automatic note(input string s);
      $display("test %s done", s);
   endtask : note

   initial begin
      logic [7:0] r;
      logic [31:0] idv;
      reset = 1'b1;
      fail_count = 0;
      checks = 0;
      cyc = 0;
      {spe, spare, bp, latch} = 7'h00;
      idv = snv_pkg::ID_VALUE;
      void'($urandom(32'h325E));
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      host.wt(4);
      srd(1);
      host.start();
      host.xfer(snv_pkg::OP_SET_WEL, 5, r);
      host.stop();
      srd(1);
      op(snv_pkg::OP_SET_WEL);
      srd(2);
      op(snv_pkg::OP_CLR_WEL);
      srd(1);
      note("latch");
      op(snv_pkg::OP_SET_WEL);
      wr(24'hFC0010, 4);
      srd(1);
      rd(snv_pkg::OP_READ, 24'h000010, 4, 1'b0);
      wr(24'h000010, 2);
      rd(snv_pkg::OP_READ, 24'h000010, 2, 1'b0);
      op(snv_pkg::OP_SET_WEL);
      wr(24'h03FFFE, 3);
      rd(snv_pkg::OP_FAST, 24'hC3FFFE, 3, 1'b0);
      rd(snv_pkg::OP_READ, 24'h03FFFE, 3, 1'b1);
      note("array");
      host.mode(1'b1);
      for (int b = 0; b < 4; b++) begin
         op(snv_pkg::OP_SET_WEL);
         srw({4'h0, 2'(b), 2'h3});
         srd(1);
         for (int j = 0; j < 3; j++) begin
            op(snv_pkg::OP_SET_WEL);
            wr(24'h01FFFF + 24'(j == 0 ? 0 : j * 32'h10000 - 32'hFFFF),
               1);
            rd(snv_pkg::OP_READ,
               24'h01FFFF + 24'(j == 0 ? 0 : j * 32'h10000 - 32'hFFFF),
               1, 1'b0);
         end
      end
      note("block protect");
      op(snv_pkg::OP_SET_WEL);
      srw(8'h80);
      host.pin(1'b0);
      op(snv_pkg::OP_SET_WEL);
      srw(8'h0C);
      srd(1);
      host.pin(1'b1);
      op(snv_pkg::OP_SET_WEL);
      srw(8'h00);
      srd(1);
      note("status protect");
      op(snv_pkg::OP_SET_WEL);
      host.start();
      host.xfer(snv_pkg::OP_CLR_WEL, 5, r);
      host.hold(1'b0);
      host.stop();
      host.hold(1'b1);
      srd(1);
      note("hold abort");
      host.start();
      host.xfer(snv_pkg::OP_ID, 8, r);
      for (int i = 3; i >= 0; i--) begin
         host.xfer(8'($urandom), 8, r);
         check("identity", idv[i*8 +: 8], r);
      end
      host.xfer(8'($urandom), 8, r);
      check("identity tail", {8{idv[0]}}, r);
      host.stop();
      note("identity");
      host.start();
      host.xfer(snv_pkg::OP_SLEEP, 8, r);
      host.pulse();
      host.stop();
      check("sleep cancelled", 8'h00, 8'(sleeping));
      host.start();
      host.xfer(snv_pkg::OP_SLEEP, 8, r);
      host.stop();
      check("asleep", 8'h01, 8'(sleeping));
      check("so enable asleep", 8'h00, 8'(soOe));
      host.start();
      check("waking", 8'h01, 8'(sleeping));
      host.stop();
      host.wt(20);
      check("awake", 8'h00, 8'(sleeping));
      srd(1);
      note("sleep");
      end_sim();
   end
endmodule : tb_spi_nv_memory_command_slave
